// [rtl/vseq_consts.svh]
// Offsets, field positions, reset values and limits of the vertical
// pattern sequencer. Included by the sequencer and its bench.
`ifndef VSEQ_CONSTS_SVH
`define VSEQ_CONSTS_SVH

// Register indices; byte address is four times the index
`define IDX_P3_LEVELS 8'h00
`define IDX_P3_OUT1 8'h01
`define IDX_P3_OUT2 8'h02
`define IDX_P3_OUT3 8'h03
`define IDX_P3_OUT4 8'h04
`define IDX_POINTERS 8'h05
`define IDX_SLOTS 8'h06
`define IDX_BOUNDS 8'h07
`define IDX_SWEEP_REP 8'h08
`define IDX_STATUS 8'h09
`define IDX_SWEEP_CFG 8'h0A

// Field positions
`define F_LEN_LSB 0
`define F_LEVEL_LSB 16
`define F_EDGE_A_LSB 0
`define F_EDGE_B_LSB 16
`define F_REPCNT_LSB 16
`define F_SWREP3_LSB 16

// Reset values and limits
`define RST_LEN 9'h001
`define SWEEP_REP_MAX 12'h800
`define LINE_MAX 8'hFF

`endif

// [rtl/vseq_pkg.sv]
// Types used by the vertical pattern sequencer alone.
// Assumes nothing of its surroundings.
package vseq_pkg;
    typedef enum logic [0:0] {
        ST_IDLE = 1'b0,
        ST_RUN = 1'b1
    } burst_state_t;
    typedef logic [2:0] region_t;
    typedef logic [1:0] pattern_id_t;
endpackage

// [rtl/ccd_vertical_pattern_sequencer.sv]
// Vertical pattern sequencer: APB register file, line and region
// tracking, burst control and the pattern three waveform.
// Assumes line and field sync arrive on pins from outside pclk's domain.
//
// Our own choice: register access over APB.
`include "vseq_consts.svh"
`timescale 1ns/1ps
`default_nettype none

module ccd_vertical_pattern_sequencer (
    // Clock and reset
    input wire logic pclk,
    input wire logic presetn,
    // APB slave
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [11:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    // Sync pins
    input wire logic line_sync,
    input wire logic field_sync,
    // Vertical outputs
    output logic [3:0] vert_out,
    // Sequencer state for the other pattern generators
    output logic burst_active,
    output logic [1:0] pattern_sel,
    output logic [8:0] pattern_pos,
    output logic sweep_active
);

    // Pattern three storage
    logic [8:0] p3_len_ff;
    logic [3:0] p3_level_ff;
    logic [8:0] p3_edge_a_ff [4];
    logic [8:0] p3_edge_b_ff [4];
    // Region and slot storage
    logic [2:0] ptr_ff [5];
    logic [1:0] slot_ff [4];
    logic [2:0] repcnt_ff [4];
    logic [7:0] bound_ff [4];
    logic [11:0] swrep_ff [2];
    logic [1:0] sweep_cfg_ff;
    // Sequencer state
    vseq_pkg::burst_state_t state_ff;
    vseq_pkg::burst_state_t nxt_state;
    logic [7:0] line_ff;
    logic [7:0] nxt_line;
    vseq_pkg::region_t region_ff;
    vseq_pkg::pattern_id_t pat_ff;
    logic sweep_ff;
    logic [8:0] pos_ff;
    logic [11:0] rep_left_ff;
    logic [3:0] vout_ff;
    logic [31:0] prdata_ff;
    // Pin synchronisers
    logic [2:0] ls_sync_ff;
    logic [2:0] fs_sync_ff;
    logic ls_filt_ff;
    logic fs_filt_ff;
    logic line_ev;
    logic field_ev;

    // Region of a line; boundaries are assumed ascending
    // region from boundaries
    function automatic vseq_pkg::region_t region_of(input logic [7:0] ln,
        input logic [7:0] b1, input logic [7:0] b2,
        input logic [7:0] b3, input logic [7:0] b4);
        if (ln >= b4) begin
            region_of = 3'd4;
        end else if (ln >= b3) begin
            region_of = 3'd3;
        end else if (ln >= b2) begin
            region_of = 3'd2;
        end else if (ln >= b1) begin
            region_of = 3'd1;
        end else begin
            region_of = 3'd0;
        end
    endfunction

    // Slot index from pointer and line parity
    function automatic logic [1:0] slot_of(input logic [2:0] ptr,
        input logic odd);
        case (ptr)
            3'd0: slot_of = 2'd0;
            3'd1: slot_of = 2'd1;
            3'd2: slot_of = 2'd2;
            3'd3: slot_of = 2'd3;
            3'd4: slot_of = {1'b0, odd};
            3'd5: slot_of = {1'b1, odd};
            // undefined pointers fall to slot 0
            default: slot_of = 2'd0;
        endcase
    endfunction

    // Register index from a byte address
    function automatic logic [7:0] index_of(input logic [11:0] a);
        index_of = a[9:2];
    endfunction

    // Three stage pin synchronisers
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            ls_sync_ff <= 3'b000;
            fs_sync_ff <= 3'b000;
        end else begin
            ls_sync_ff <= {ls_sync_ff[1:0], line_sync};
            fs_sync_ff <= {fs_sync_ff[1:0], field_sync};
        end
    end

    // Filtered levels change only once stages two and three agree
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            ls_filt_ff <= 1'b0;
            fs_filt_ff <= 1'b0;
        end else begin
            if (ls_sync_ff[1] == ls_sync_ff[2]) begin
                ls_filt_ff <= ls_sync_ff[2];
            end
            if (fs_sync_ff[1] == fs_sync_ff[2]) begin
                fs_filt_ff <= fs_sync_ff[2];
            end
        end
    end

    // Rising edges of the filtered levels
    assign line_ev = (ls_sync_ff[1] & ls_sync_ff[2]) & ~ls_filt_ff;
    assign field_ev = (fs_sync_ff[1] & fs_sync_ff[2]) & ~fs_filt_ff;

    // APB access decode
    logic wr_en;
    logic rd_setup;
    logic [7:0] wr_idx;
    logic [7:0] rd_idx;
    logic mapped;
    assign wr_en = psel & penable & pwrite;
    assign rd_setup = psel & ~penable & ~pwrite;
    assign wr_idx = index_of(paddr);
    assign rd_idx = index_of(paddr);
    assign mapped = (paddr[11:10] == 2'b00) && (paddr[1:0] == 2'b00)
        && (rd_idx <= `IDX_SWEEP_CFG);
    // Zero wait states; unmapped or misaligned access errors
    assign pready = 1'b1;
    assign pslverr = psel & penable & ~mapped;

    // Pattern three register writes
    // pattern three storage
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            p3_len_ff <= `RST_LEN;
            p3_level_ff <= 4'h0;
            for (int i = 0; i < 4; i++) begin
                p3_edge_a_ff[i] <= 9'h000;
                p3_edge_b_ff[i] <= 9'h000;
            end
        end else if (wr_en && mapped) begin
            if (wr_idx == `IDX_P3_LEVELS) begin
                p3_len_ff <= pwdata[`F_LEN_LSB +: 9];
                p3_level_ff <= pwdata[`F_LEVEL_LSB +: 4];
            end
            for (int i = 0; i < 4; i++) begin
                if (wr_idx == `IDX_P3_OUT1 + 8'(i)) begin
                    p3_edge_a_ff[i] <= pwdata[`F_EDGE_A_LSB +: 9];
                    p3_edge_b_ff[i] <= pwdata[`F_EDGE_B_LSB +: 9];
                end
            end
        end
    end

    // Region, slot, repeat and boundary register writes
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            for (int i = 0; i < 5; i++) begin
                ptr_ff[i] <= 3'h0;
            end
            for (int i = 0; i < 4; i++) begin
                slot_ff[i] <= 2'h0;
                repcnt_ff[i] <= 3'h0;
                bound_ff[i] <= `LINE_MAX;
            end
        end else if (wr_en && mapped) begin
            for (int i = 0; i < 5; i++) begin
                if (wr_idx == `IDX_POINTERS) begin
                    ptr_ff[i] <= pwdata[i*4 +: 3];
                end
            end
            for (int i = 0; i < 4; i++) begin
                if (wr_idx == `IDX_SLOTS) begin
                    slot_ff[i] <= pwdata[i*4 +: 2];
                    repcnt_ff[i] <= pwdata[`F_REPCNT_LSB + i*4 +: 3];
                end
                if (wr_idx == `IDX_BOUNDS) begin
                    bound_ff[i] <= pwdata[i*8 +: 8];
                end
            end
        end
    end

    // Sweep register writes; counts above the maximum are clamped
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            swrep_ff[0] <= 12'h000;
            swrep_ff[1] <= 12'h000;
            sweep_cfg_ff <= 2'b00;
        end else if (wr_en && mapped) begin
            if (wr_idx == `IDX_SWEEP_REP) begin
                swrep_ff[0] <= (pwdata[11:0] > `SWEEP_REP_MAX) ?
                    `SWEEP_REP_MAX : pwdata[11:0];
                swrep_ff[1] <= (pwdata[`F_SWREP3_LSB +: 12] > `SWEEP_REP_MAX)
                    ? `SWEEP_REP_MAX : pwdata[`F_SWREP3_LSB +: 12];
            end
            if (wr_idx == `IDX_SWEEP_CFG) begin
                sweep_cfg_ff <= pwdata[1:0];
            end
        end
    end

    // Read data is captured in the setup phase so it is stable in access
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            prdata_ff <= 32'h0000_0000;
        end else if (rd_setup) begin
            prdata_ff <= 32'h0000_0000;
            case (rd_idx)
                `IDX_P3_LEVELS: begin
                    prdata_ff[`F_LEN_LSB +: 9] <= p3_len_ff;
                    prdata_ff[`F_LEVEL_LSB +: 4] <= p3_level_ff;
                end
                `IDX_P3_OUT1, `IDX_P3_OUT2, `IDX_P3_OUT3, `IDX_P3_OUT4: begin
                    prdata_ff[`F_EDGE_A_LSB +: 9] <= p3_edge_a_ff[rd_idx[1:0]
                        - 2'd1];
                    prdata_ff[`F_EDGE_B_LSB +: 9] <= p3_edge_b_ff[rd_idx[1:0]
                        - 2'd1];
                end
                `IDX_POINTERS: begin
                    prdata_ff <= {12'h000, 1'b0, ptr_ff[4], 1'b0, ptr_ff[3],
                        1'b0, ptr_ff[2], 1'b0, ptr_ff[1], 1'b0, ptr_ff[0]};
                end
                `IDX_SLOTS: begin
                    prdata_ff <= {1'b0, repcnt_ff[3], 1'b0, repcnt_ff[2],
                        1'b0, repcnt_ff[1], 1'b0, repcnt_ff[0],
                        2'b00, slot_ff[3], 2'b00, slot_ff[2],
                        2'b00, slot_ff[1], 2'b00, slot_ff[0]};
                end
                `IDX_BOUNDS: begin
                    prdata_ff <= {bound_ff[3], bound_ff[2], bound_ff[1],
                        bound_ff[0]};
                end
                `IDX_SWEEP_REP: begin
                    prdata_ff <= {4'h0, swrep_ff[1], 4'h0, swrep_ff[0]};
                end
                `IDX_STATUS: begin
                    prdata_ff <= {4'h0, rep_left_ff, line_ff, sweep_ff,
                        region_ff, state_ff, pat_ff, 1'b0};
                end
                `IDX_SWEEP_CFG: begin
                    prdata_ff[1:0] <= sweep_cfg_ff;
                end
                default: begin
                    prdata_ff <= 32'h0000_0000;
                end
            endcase
        end
    end
    assign prdata = prdata_ff;

    // Next line number; a field sync restarts at line 0
    always_comb begin
        nxt_line = line_ff;
        if (field_ev) begin
            nxt_line = 8'h00;
        end else if (line_ev && (line_ff != `LINE_MAX)) begin
            nxt_line = line_ff + 8'h01;
        end
    end

    // Choice of pattern and repeats for the line about to start
    vseq_pkg::region_t nreg;
    logic [1:0] nslot;
    vseq_pkg::pattern_id_t npat;
    logic nsweep;
    logic [11:0] nreps;
    logic start;
    always_comb begin
        nreg = region_of(nxt_line, bound_ff[0], bound_ff[1], bound_ff[2],
            bound_ff[3]);
        nslot = slot_of(ptr_ff[nreg], nxt_line[0]);
        npat = slot_ff[nslot];
        nsweep = ((nreg == 3'd0) && sweep_cfg_ff[0])
            || ((nreg == 3'd3) && sweep_cfg_ff[1]);
        if (nsweep) begin
            nreps = swrep_ff[nreg == 3'd3];
        end else begin
            nreps = {9'h000, repcnt_ff[npat]};
        end
        // sweep ignores line sync inside its region
        start = field_ev || (line_ev && !(sweep_ff && (nreg == region_ff)));
    end

    // Last position of a repetition; a zero length acts as one
    logic [8:0] last_pos;
    assign last_pos = (p3_len_ff == 9'h000) ? 9'h000 : p3_len_ff - 9'h001;

    // Burst state
    always_comb begin
        nxt_state = state_ff;
        if (start) begin
            nxt_state = (nreps == 12'h000) ? vseq_pkg::ST_IDLE
                : vseq_pkg::ST_RUN;
        end else begin
            case (state_ff)
                vseq_pkg::ST_IDLE: nxt_state = vseq_pkg::ST_IDLE;
                vseq_pkg::ST_RUN: begin
                    if ((pos_ff == last_pos) && (rep_left_ff == 12'h001)) begin
                        nxt_state = vseq_pkg::ST_IDLE;
                    end
                end
                default: nxt_state = vseq_pkg::ST_IDLE;
            endcase
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            state_ff <= vseq_pkg::ST_IDLE;
        end else begin
            state_ff <= nxt_state;
        end
    end

    // Line tracked every cycle; region, pattern and sweep latched at each burst start
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            line_ff <= 8'h00;
            region_ff <= 3'd0;
            pat_ff <= 2'd0;
            sweep_ff <= 1'b0;
        end else begin
            line_ff <= nxt_line;
            if (start) begin
                region_ff <= nreg;
                pat_ff <= npat;
                sweep_ff <= nsweep;
            end
        end
    end

    // Position and repetition counters
    // restart after length
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            pos_ff <= 9'h000;
            rep_left_ff <= 12'h000;
        end else if (start) begin
            pos_ff <= 9'h000;
            rep_left_ff <= nreps;
        end else if (state_ff == vseq_pkg::ST_RUN) begin
            if (pos_ff == last_pos) begin
                pos_ff <= 9'h000;
                rep_left_ff <= rep_left_ff - 12'h001;
            end else begin
                pos_ff <= pos_ff + 9'h001;
            end
        end
    end

    // Pattern three waveform; other patterns hold the outputs low
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            vout_ff <= 4'h0;
        end else begin
            for (int i = 0; i < 4; i++) begin
                if (pat_ff != 2'd3) begin
                    vout_ff[i] <= 1'b0;
                end else if (state_ff == vseq_pkg::ST_RUN) begin
                    vout_ff[i] <= p3_level_ff[i]
                        ^ (pos_ff >= p3_edge_a_ff[i])
                        ^ (pos_ff >= p3_edge_b_ff[i]);
                end else begin
                    vout_ff[i] <= p3_level_ff[i];
                end
            end
        end
    end

    // Outputs
    assign vert_out = vout_ff;
    assign burst_active = (state_ff == vseq_pkg::ST_RUN);
    assign pattern_sel = pat_ff;
    assign pattern_pos = pos_ff;
    assign sweep_active = sweep_ff & (state_ff == vseq_pkg::ST_RUN);

endmodule // ccd_vertical_pattern_sequencer

`default_nettype wire

// [verif/vseq_props.sv]
// Port checker for the vertical pattern sequencer.
// Assumes APB writes land on the access edge, as the design states.
`include "vseq_consts.svh"
`timescale 1ns/1ps
`default_nettype none

module vseq_props (
    // Clock, reset and APB
    input wire logic pclk,
    input wire logic presetn,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [11:0] paddr,
    input wire logic [31:0] pwdata,
    input wire logic pready,
    input wire logic pslverr,
    // Sequencer outputs
    input wire logic [3:0] vert_out,
    input wire logic burst_active,
    input wire logic [1:0] pattern_sel,
    input wire logic [8:0] pattern_pos,
    input wire logic sweep_active
);
    default clocking @(posedge pclk); endclocking
    default disable iff (!presetn);
    logic [8:0] len_ff;
    logic [3:0] lvl_ff;
    logic [8:0] ea_ff [4];
    logic [8:0] eb_ff [4];
    logic [1:0] cfg_ff;
    logic bad, wr;
    logic [8:0] last;
    logic [3:0] wave;
    // Shadow copies; a length of 0 runs like 1
    assign bad = (paddr[11:2] > 10'h00A) || (paddr[1:0] != 2'h0);
    assign wr = psel && penable && pwrite && pready && !bad;
    assign last = (len_ff == 9'h000) ? 9'h000 : len_ff - 9'h001;
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            len_ff <= 9'h001;
            lvl_ff <= 4'h0;
            cfg_ff <= 2'h0;
            for (int i = 0; i < 4; i++) begin
                ea_ff[i] <= 9'h000;
                eb_ff[i] <= 9'h000;
            end
        end else if (wr) begin
            if (paddr[9:2] == `IDX_P3_LEVELS) begin
                len_ff <= pwdata[8:0];
                lvl_ff <= pwdata[19:16];
            end
            if (paddr[9:2] == `IDX_SWEEP_CFG) begin
                cfg_ff <= pwdata[1:0];
            end
            for (int i = 0; i < 4; i++) begin
                if (paddr[9:2] == `IDX_P3_OUT1 + i) begin
                    ea_ff[i] <= pwdata[8:0];
                    eb_ff[i] <= pwdata[24:16];
                end
            end
        end
    end
    // Expected pattern three levels at the current position
    always_comb begin
        for (int i = 0; i < 4; i++) begin
            wave[i] = lvl_ff[i] ^ (pattern_pos >= ea_ff[i])
                ^ (pattern_pos >= eb_ff[i]);
        end
    end
    sequence s_access;
        psel && penable;
    endsequence
    sequence s_p3_run;
        burst_active && pattern_sel == 2'd3;
    endsequence
    a_pready_access: assert property (s_access |-> pready)
        else $error("pready low in access");
    a_bad_addr_err: assert property (s_access and bad |-> pslverr)
        else $error("no error on bad address");
    a_good_addr_ok: assert property (s_access and !bad |-> !pslverr)
        else $error("error on mapped address");
    a_err_only_access: assert property (!(psel && penable) |-> !pslverr)
        else $error("pslverr outside access");
    a_pos_step: assert property (s_p3_run and pattern_pos < last
        |=> burst_active && pattern_pos == $past(pattern_pos) + 9'd1)
        else $error("position did not step");
    a_pos_wrap: assert property (s_p3_run and pattern_pos == last
        |=> !burst_active || pattern_pos == 9'd0)
        else $error("position did not wrap");
    a_out_wave: assert property (s_p3_run |=> vert_out == $past(wave))
        else $error("vertical output level wrong");
    a_other_pat_low: assert property (burst_active && pattern_sel != 2'd3
        |=> vert_out == 4'h0)
        else $error("outputs driven for pattern 0-2");
    a_sweep_cfg: assert property (sweep_active
        |-> burst_active && cfg_ff != 2'b00)
        else $error("sweep with sweep disabled");
endmodule // vseq_props

bind ccd_vertical_pattern_sequencer vseq_props u_props (
    .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pready(pready),
    .pslverr(pslverr), .vert_out(vert_out), .burst_active(burst_active),
    .pattern_sel(pattern_sel), .pattern_pos(pattern_pos),
    .sweep_active(sweep_active));
`default_nettype wire

// [verif/ccd_vert_load.sv]
// Behavioural CCD load on the vertical phases: counts shift steps.
// Assumes one rise of phase one moves charge by one line.
`timescale 1ns/1ps
`default_nettype none

module ccd_vert_load (
    // Clock and reset
    input wire logic pclk,
    input wire logic presetn,
    // Vertical phases
    input wire logic [3:0] vert_out,
    // Shift steps seen
    output logic [15:0] shifts
);
    logic prev_ff;
    logic [15:0] count_ff;
    // Edge detect only; a level held high is a single shift
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            prev_ff <= 1'b0;
            count_ff <= 16'h0000;
        end else begin
            prev_ff <= vert_out[0];
            if (vert_out[0] && !prev_ff) begin
                count_ff <= count_ff + 16'h0001;
            end
        end
    end
    assign shifts = count_ff;
endmodule // ccd_vert_load
`default_nettype wire

// [verif/tb.sv]
// Self-checking bench for the vertical pattern sequencer.
// Assumes 40 MHz pclk, zero-wait APB and syncs seen after 3 flops.
`include "vseq_consts.svh"
`timescale 1ns/1ps
`default_nettype none

module tb;
    logic pclk = 1'b0;
    logic presetn = 1'b0;
    logic psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
    logic [11:0] paddr = 12'h000;
    logic [31:0] pwdata = 32'h0000_0000;
    logic line_sync = 1'b0, field_sync = 1'b0;
    logic [31:0] prdata, rd;
    logic pready, pslverr, burst_active, sweep_active, err;
    logic [3:0] vert_out;
    logic [1:0] pattern_sel, sel;
    logic [8:0] pattern_pos;
    logic [15:0] shifts;
    int miscompares = 0, num_checks = 0, hi, sw;

    // 25 ns period
    always #12.5 pclk = ~pclk;

    ccd_vertical_pattern_sequencer u_dut (.pclk(pclk), .presetn(presetn),
        .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
        .pwdata(pwdata), .prdata(prdata), .pready(pready),
        .pslverr(pslverr), .line_sync(line_sync), .field_sync(field_sync),
        .vert_out(vert_out), .burst_active(burst_active),
        .pattern_sel(pattern_sel), .pattern_pos(pattern_pos),
        .sweep_active(sweep_active));
    ccd_vert_load u_load (.pclk(pclk), .presetn(presetn),
        .vert_out(vert_out), .shifts(shifts));

    function automatic logic [11:0] a4(input logic [7:0] i);
        return {2'b00, i, 2'b00};
    endfunction

    task check(input logic [31:0] got, input logic [31:0] exp);
        num_checks++;
        if (got !== exp) begin
            miscompares++;
            $display("CHECK FAILED t=%0t got %h exp %h", $time, got, exp);
        end
    endtask

    // APB transfer; request held until pready is seen at an edge
    task apb(input logic w, input logic [11:0] a, input logic [31:0] d);
        @(posedge pclk);
        psel <= 1'b1;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge pclk);
        penable <= 1'b1;
        // No cycle count assumed; only the watchdog ends a hung transfer
        do begin
            @(posedge pclk);
        end while (pready !== 1'b1);
        rd = prdata;
        err = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask

    // 50-cycle window: sync pulses of 4 cycles, burst activity counted
    task run(input logic fld, input logic ln, input logic inj);
        logic seen;
        hi = 0;
        sw = 0;
        seen = 1'b0;
        sel = 2'h0;
        for (int i = 0; i < 50; i++) begin
            @(posedge pclk);
            field_sync <= fld && (i < 4);
            line_sync <= (ln && (i < 4)) || (inj && i >= 12 && i < 16);
            #1;
            if (burst_active === 1'b1) begin
                if (!seen) sel = pattern_sel;
                seen = 1'b1;
                hi++;
            end
            if (sweep_active === 1'b1) sw++;
        end
    endtask

    // Reset values, field widths, clamping and refused addresses
    task automatic t_regs;
        logic [7:0] ix [7] = '{8'h00, 8'h01, 8'h05, 8'h06, 8'h07, 8'h08,
            8'h0A};
        logic [31:0] ev [7] = '{32'h0000_0001, 0, 0, 0, 32'hFFFF_FFFF, 0, 0};
        for (int i = 0; i < 7; i++) begin
            apb(1'b0, a4(ix[i]), 0);
            check(rd, ev[i]);
        end
        apb(1'b1, a4(`IDX_P3_OUT1), 32'h01FF_01FF);
        apb(1'b0, a4(`IDX_P3_OUT1), 0);
        check(rd, 32'h01FF_01FF);
        apb(1'b1, a4(`IDX_SWEEP_REP), 32'h0FFF_0FFF);
        apb(1'b0, a4(`IDX_SWEEP_REP), 0);
        check(rd, 32'h0800_0800);
        apb(1'b1, a4(`IDX_SWEEP_CFG), 32'hFFFF_FFFF);
        apb(1'b0, a4(`IDX_SWEEP_CFG), 0);
        check(rd, 32'h0000_0003);
        apb(1'b1, a4(`IDX_SWEEP_CFG), 0);
        apb(1'b0, 12'h02C, 32'h0000_0000);
        check({31'h0, err}, 32'h0000_0001);
        check(rd, 32'h0000_0000);
        apb(1'b1, 12'h006, 32'hFFFF_FFFF);
        check({31'h0, err}, 32'h0000_0001);
        // A misaligned write must leave the edge register untouched
        apb(1'b0, a4(`IDX_P3_OUT1), 0);
        check(rd, 32'h01FF_01FF);
    endtask

    // Lines 0 to 9 over five regions, pointer 4 then pointer 5
    task t_regions;
        logic [1:0] slot;
        apb(1'b1, a4(`IDX_SLOTS), 32'h1111_0123);
        apb(1'b1, a4(`IDX_BOUNDS), 32'h0806_0402);
        for (int p = 4; p < 6; p++) begin
            apb(1'b1, a4(`IDX_POINTERS), {12'h000, p[3:0], 16'h3210});
            for (int ln = 0; ln < 10; ln++) begin
                run(ln == 0, ln != 0, 1'b0);
                slot = (ln < 8) ? ln[2:1] : {p == 5, ln[0]};
                check({30'h0, sel}, {30'h0, ~slot});
            end
        end
    endtask

    task t_sweep;
        int reps;
        logic [15:0] s0;
        apb(1'b1, a4(`IDX_P3_LEVELS), 32'h000A_0004);
        apb(1'b1, a4(`IDX_P3_OUT1), 32'h0003_0001);
        apb(1'b1, a4(`IDX_SLOTS), 32'h7000_0003);
        apb(1'b1, a4(`IDX_POINTERS), 32'h0000_0000);
        apb(1'b1, a4(`IDX_BOUNDS), 32'hC801_0101);
        apb(1'b1, a4(`IDX_SWEEP_REP), 32'h0003_0005);
        for (int c = 0; c < 4; c++) begin
            apb(1'b1, a4(`IDX_SWEEP_CFG), c);
            for (int ln = 0; ln < 2; ln++) begin
                s0 = shifts;
                run(ln == 0, ln == 1, ln == 1 && c[1]);
                reps = (ln == 0) ? (c[0] ? 5 : 7) : (c[1] ? 3 : 7);
                check(hi, reps * 4);
                check(sw, (reps != 7) ? reps * 4 : 0);
                check(shifts - s0, reps);
            end
        end
    endtask

    task print_verdict;
        if (miscompares == 0 && num_checks > 0) begin
            $display("verification passed");
        end else begin
            $display("verification failed");
        end
        $finish;
    endtask

    // Watchdog well above the roughly 1500 cycles the tests need
    initial begin
        repeat (20000) @(posedge pclk);
        miscompares++;
        print_verdict();
    end

    initial begin
        repeat (8) @(posedge pclk);
        presetn <= 1'b1;
        t_regs();
        t_regions();
        t_sweep();
        print_verdict();
    end
endmodule // tb
`default_nettype wire
